// file: core/crystal_osc_control.v
// crystal oscillator control: register slave, gating, start-up and ready logic
`include "crystal_osc_defs.vh"

module crystal_osc_control #(
  parameter NUM_REQ = 4
) (
  input  wire               sys_clk,
  input  wire               rstn,
  input  wire               clkEn,
  // classic wishbone slave
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  input  wire               wb_we_i,
  input  wire [3:0]         wb_adr_i,
  input  wire [3:0]         wb_sel_i,
  input  wire [31:0]        wb_dat_i,
  output reg  [31:0]        wb_dat_o,
  output reg                wb_ack_o,
  output reg                wb_err_o,
  // system side
  input  wire               standby,
  input  wire [NUM_REQ-1:0] clkReq,
  input  wire               slowTick,
  input  wire               fastTick,
  output reg  [NUM_REQ-1:0] clkGrant,
  output reg                oscRun,
  output reg                crystalPadSelect,
  output reg                outPadFree,
  output reg  [2:0]         oscGain,
  output reg                autoAmpGainCtl,
  output reg                crystalReadyFlag,
  output reg                irq
);

  // ======================================================
  // registers
  reg  [15:0] ctrl_q;
  reg  [1:0]  intFlag_q;
  reg  [1:0]  intMask_q;
  reg         oscOn_q;
  reg         ready_q;
  reg         doneSeen_q;
  reg         gainErr_q;

  wire        enableBit   = ctrl_q[`XO_ENABLE_BIT];
  wire        onReq       = ctrl_q[`XO_ONREQ_BIT];
  wire        keepStby    = ctrl_q[`XO_KEEPSTBY_BIT];
  wire [3:0]  startupSel  = ctrl_q[`XO_STARTUP_HI:`XO_STARTUP_LO];
  wire        anyReq      = |clkReq;

  // ======================================================
  // run decision
  reg runWant;

  // enable gates the run decision; standby and on-request narrow it further
  always @* begin
    runWant = 1'b0;
    if (enableBit) begin
      if (onReq)
        runWant = anyReq;
      else if (standby)
        runWant = keepStby | anyReq;
      else
        runWant = 1'b1;
    end
  end

  wire startPulse = runWant & ~oscOn_q;
  wire counterDone;

  // ======================================================
  // start-up timer
  xo_startup_counter #(
    .SEL_W (4),
    .CNT_W (16)
  ) u_startup (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .clkEn      (clkEn),
    .restart    (startPulse),
    .slowTick   (slowTick),
    .fastTick   (fastTick),
    .startupSel (startupSel),
    .done       (counterDone)
  );

  // ======================================================
  // wishbone decode
  wire        busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire        hitCtrl = (wb_adr_i == `XO_CTRL_OFS);
  wire        hitStat = (wb_adr_i == `XO_STATUS_OFS);
  wire        hitFlag = (wb_adr_i == `XO_INTFLAG_OFS);
  wire        hitMask = (wb_adr_i == `XO_INTMASK_OFS);
  wire        mapped  = hitCtrl | hitStat | hitFlag | hitMask;
  wire        wrCtrl  = busReq & wb_we_i & hitCtrl;
  wire        wrFlag  = busReq & wb_we_i & hitFlag & wb_sel_i[0];
  wire        wrMask  = busReq & wb_we_i & hitMask & wb_sel_i[0];

  // byte-lane merge of a control write, unimplemented bits stay zero
  reg  [15:0] ctrlWrite;
  always @* begin
    ctrlWrite = ctrl_q;
    if (wb_sel_i[0]) ctrlWrite[7:0]  = wb_dat_i[7:0];
    if (wb_sel_i[1]) ctrlWrite[15:8] = wb_dat_i[15:8];
    ctrlWrite = ctrlWrite & `XO_CTRL_WMASK;
  end

  // reserved gain codes are rejected; the old gain is kept so the
  // oscillator never runs with an undefined drive setting
  wire gainBad = wb_sel_i[1] &
                 (wb_dat_i[`XO_GAIN_HI:`XO_GAIN_LO] > `XO_GAIN_MAXOK);

  // control register write
  always @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_q    <= `XO_CTRL_RESET;
      gainErr_q <= 1'b0;
    end else if (clkEn && wrCtrl) begin
      if (gainBad) begin
        ctrl_q    <= {ctrlWrite[15:11], ctrl_q[10:8], ctrlWrite[7:0]};
        gainErr_q <= 1'b1;
      end else begin
        ctrl_q    <= ctrlWrite;
        gainErr_q <= 1'b0;
      end
    end
  end

  // ======================================================
  // oscillator state, ready flag
  always @(posedge sys_clk) begin
    if (!rstn) begin
      oscOn_q    <= 1'b0;
      ready_q    <= 1'b0;
      doneSeen_q <= 1'b0;
    end else if (clkEn) begin
      oscOn_q    <= runWant;
      doneSeen_q <= counterDone;
      if (!runWant || startPulse)
        ready_q <= 1'b0;
      else if (counterDone && !doneSeen_q)
        ready_q <= 1'b1;
    end
  end

  // ======================================================
  // interrupts: ready rise and ready loss, write one to clear
  wire evReady = ready_q & ~crystalReadyFlag & clkEn;
  wire evLost  = ~ready_q & crystalReadyFlag & clkEn;

  // set wins over a clear arriving in the same cycle
  always @(posedge sys_clk) begin
    if (!rstn) begin
      intFlag_q <= 2'h0;
      intMask_q <= 2'h0;
    end else if (clkEn) begin
      intFlag_q[`XO_IRQ_READY] <= evReady |
        (intFlag_q[`XO_IRQ_READY] & ~(wrFlag & wb_dat_i[`XO_IRQ_READY]));
      intFlag_q[`XO_IRQ_LOST]  <= evLost |
        (intFlag_q[`XO_IRQ_LOST] & ~(wrFlag & wb_dat_i[`XO_IRQ_LOST]));
      if (wrMask) intMask_q <= wb_dat_i[1:0];
    end
  end

  // ======================================================
  // bus answer, one wait state, error on unmapped address
  always @(posedge sys_clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clkEn) begin
      wb_ack_o <= busReq & mapped;
      wb_err_o <= busReq & ~mapped;
      wb_dat_o <= 32'h00000000;
      if (busReq && !wb_we_i) begin
        if (hitCtrl)
          wb_dat_o <= {16'h0000, ctrl_q};
        else if (hitStat)
          wb_dat_o <= {28'h0000000, gainErr_q, counterDone, oscOn_q, ready_q};
        else if (hitFlag)
          wb_dat_o <= {30'h00000000, intFlag_q};
        else if (hitMask)
          wb_dat_o <= {30'h00000000, intMask_q};
      end
    end
  end

  // ======================================================
  // registered outputs toward the analog cell and the requesters
  always @(posedge sys_clk) begin
    if (!rstn) begin
      clkGrant         <= {NUM_REQ{1'b0}};
      oscRun           <= 1'b0;
      crystalPadSelect <= 1'b0;
      outPadFree       <= 1'b1;
      oscGain          <= 3'h0;
      autoAmpGainCtl   <= 1'b0;
      crystalReadyFlag <= 1'b0;
      irq              <= 1'b0;
    end else if (clkEn) begin
      clkGrant         <= clkReq & {NUM_REQ{ready_q}};
      oscRun           <= runWant;
      crystalPadSelect <= ctrl_q[`XO_PADSEL_BIT];
      outPadFree       <= ~ctrl_q[`XO_PADSEL_BIT];
      oscGain          <= ctrl_q[`XO_GAIN_HI:`XO_GAIN_LO];
      // amplitude loop only acts while the oscillator actually runs
      autoAmpGainCtl   <= ctrl_q[`XO_AGC_BIT] & runWant;
      crystalReadyFlag <= ready_q;
      irq              <= |(intFlag_q & intMask_q);
    end
  end

endmodule // crystal_osc_control

// file: core/crystal_osc_defs.vh
// constants for the crystal oscillator control block
`ifndef CRYSTAL_OSC_DEFS_VH
`define CRYSTAL_OSC_DEFS_VH

// ======================================================
// register word offsets (byte addresses)
`define XO_CTRL_OFS      4'h0
`define XO_STATUS_OFS    4'h4
`define XO_INTFLAG_OFS   4'h8
`define XO_INTMASK_OFS   4'hC

// ======================================================
// control field positions
`define XO_ENABLE_BIT    1
`define XO_PADSEL_BIT    2
`define XO_KEEPSTBY_BIT  6
`define XO_ONREQ_BIT     7
`define XO_GAIN_LO       8
`define XO_GAIN_HI       10
`define XO_AGC_BIT       11
`define XO_STARTUP_LO    12
`define XO_STARTUP_HI    15

// ======================================================
// reset values and writable masks
`define XO_CTRL_RESET    16'h0080
`define XO_CTRL_WMASK    16'hFFC6
`define XO_GAIN_MAXOK    3'h4

// ======================================================
// timing counts
`define XO_PRE_CYCLES    2'h3
`define XO_SLOW_SYNC     2

// ======================================================
// interrupt bits
`define XO_IRQ_READY     0
`define XO_IRQ_LOST      1

`endif

// file: core/xo_startup_counter.v
// start-up timer: three crystal cycles, then 2^sel slow-oscillator ticks
`include "crystal_osc_defs.vh"

module xo_startup_counter #(
  parameter SEL_W = 4,
  parameter CNT_W = 16
) (
  input  wire             sys_clk,
  input  wire             rstn,
  input  wire             clkEn,
  input  wire             restart,
  input  wire             slowTick,
  input  wire             fastTick,
  input  wire [SEL_W-1:0] startupSel,
  output reg              done
);

  // ======================================================
  // counters
  reg [1:0]       preCnt_q;
  reg [CNT_W:0]   slowCnt_q;
  reg             running_q;
  wire [CNT_W:0]  target = {{CNT_W{1'b0}}, 1'b1} << startupSel;

  // restart clears both counters and done and sets running; crystal edges counted first, then slow ticks
  always @(posedge sys_clk) begin
    if (!rstn) begin
      preCnt_q  <= 2'h0;
      slowCnt_q <= {(CNT_W+1){1'b0}};
      running_q <= 1'b0;
      done      <= 1'b0;
    end else if (clkEn) begin
      if (restart) begin
        preCnt_q  <= 2'h0;
        slowCnt_q <= {(CNT_W+1){1'b0}};
        running_q <= 1'b1;
        done      <= 1'b0;
      end else if (running_q) begin
        if (preCnt_q != `XO_PRE_CYCLES) begin
          if (fastTick) preCnt_q <= preCnt_q + 2'h1;
        end else if (slowTick) begin
          if (slowCnt_q + 1'b1 == target) begin
            running_q <= 1'b0;
            done      <= 1'b1;
          end
          slowCnt_q <= slowCnt_q + 1'b1;
        end
      end
    end
  end

endmodule // xo_startup_counter

// file: test/clk_requester.sv
// peripheral model: registered clock requests toward the oscillator control
module clk_requester (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] want,
  output logic      [3:0] clkReq
);
  timeunit 1ns;
  timeprecision 1ps;
  // requests change only after an edge, as a real peripheral would
  always @(posedge sys_clk) begin
    clkReq <= rstn ? want : 4'h0;
  end
endmodule // clk_requester

// file: test/crystal_osc_control_chk.sv
// assertion checker for the crystal oscillator control block
module crystal_osc_control_chk #(
  parameter NUM_REQ = 4
) (
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               clkEn,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               wb_err_o,
  input wire logic [NUM_REQ-1:0] clkReq,
  input wire logic [NUM_REQ-1:0] clkGrant,
  input wire logic               oscRun,
  input wire logic               crystalPadSelect,
  input wire logic               outPadFree,
  input wire logic [2:0]         oscGain,
  input wire logic               autoAmpGainCtl,
  input wire logic               crystalReadyFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ======================================================
  // bus handshake
  sequence s_take; wb_cyc_i && wb_stb_i && clkEn && !wb_ack_o && !wb_err_o; endsequence
  property p_ack; s_take |=> wb_ack_o || wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("no answer to request");
  property p_ackone; wb_ack_o && clkEn |=> !wb_ack_o; endproperty
  a_ackone: assert property (p_ackone) else $error("ack longer than one cycle");
  // ======================================================
  // oscillator outputs
  sequence s_quiet; !crystalReadyFlag [*3]; endsequence
  property p_restart; $rose(oscRun) |=> ##1 s_quiet; endproperty
  a_restart: assert property (p_restart) else $error("ready kept over restart");
  property p_grant; $past(clkEn) |-> clkGrant == ($past(clkReq) & {NUM_REQ{crystalReadyFlag}});
  endproperty
  a_grant: assert property (p_grant) else $error("grant without ready");
  // ready may only stand while the oscillator has been running
  property p_rdyrun; crystalReadyFlag |-> $past(oscRun, 2); endproperty
  a_rdyrun: assert property (p_rdyrun) else $error("ready while stopped");
  property p_pad; outPadFree != crystalPadSelect; endproperty
  a_pad: assert property (p_pad) else $error("pad select mismatch");
  property p_gain; oscGain <= 3'h4; endproperty
  a_gain: assert property (p_gain) else $error("reserved gain used");
  property p_agc; autoAmpGainCtl |-> oscRun || $past(oscRun); endproperty
  a_agc: assert property (p_agc) else $error("gain control while stopped");
endmodule // crystal_osc_control_chk

bind crystal_osc_control crystal_osc_control_chk #(.NUM_REQ(NUM_REQ)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .clkReq(clkReq), .clkGrant(clkGrant),
  .oscRun(oscRun), .crystalPadSelect(crystalPadSelect), .outPadFree(outPadFree),
  .oscGain(oscGain), .autoAmpGainCtl(autoAmpGainCtl), .crystalReadyFlag(crystalReadyFlag));

// file: test/crystal_osc_control_tb_top.sv
// testbench for the crystal oscillator control block
module crystal_osc_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rstn = 0, clkEn = 1, standby = 0, slowTick = 0, fastTick = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o, er;
  logic        oscRun, crystalPadSelect, outPadFree, autoAmpGainCtl, crystalReadyFlag, irq;
  logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'hF, want = 0, clkReq, clkGrant;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic [2:0]  oscGain;
  int          errors = 0, testsRun = 0;
  // clock at 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  crystal_osc_control #(.NUM_REQ(4)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .clkEn(clkEn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .standby(standby), .clkReq(clkReq), .slowTick(slowTick),
    .fastTick(fastTick), .clkGrant(clkGrant), .oscRun(oscRun),
    .crystalPadSelect(crystalPadSelect), .outPadFree(outPadFree), .oscGain(oscGain),
    .autoAmpGainCtl(autoAmpGainCtl), .crystalReadyFlag(crystalReadyFlag), .irq(irq));
  clk_requester i_req (.sys_clk(sys_clk), .rstn(rstn), .want(want), .clkReq(clkReq));
  // ======================================================
  // helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    testsRun++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("errors %0d compares %0d", errors, testsRun);
    if (errors == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one classic cycle; request held until ack or err is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      cyc(1);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    chk(n < 20, 1);
    if (n >= 20) end_of_test;
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    cyc(1);
  endtask
  task waitRun(input logic e);
    int n;
    n = 0;
    while (oscRun !== e && n < 20) begin
      cyc(1);
      n++;
    end
    chk(oscRun, e);
    if (n >= 20) end_of_test;
  endtask
  // fast pulses first, then slow, each followed by an idle cycle
  task ticks(input int f, input int s);
    for (int i = 0; i < f + s; i++) begin
      fastTick <= (i < f);
      slowTick <= (i >= f);
      cyc(1);
      fastTick <= 0;
      slowTick <= 0;
      cyc(1);
    end
  endtask
  // ======================================================
  // main sequence
  initial begin
    cyc(10);
    rstn <= 1;
    cyc(1);
    wb(0, 4'h0, 0);
    chk(rd, 32'h00000080);
    wb(0, 4'h1, 0);
    chk(er, 1'b1);
    wb(1, 4'h0, 32'h00000404);
    cyc(2);
    chk({oscGain, crystalPadSelect, outPadFree, oscRun}, 6'h24);
    wb(1, 4'h0, 32'h00000500);
    wb(0, 4'h0, 0);
    chk(rd, 32'h00000400);
    wb(0, 4'h4, 0);
    chk(rd, 32'h00000008);
    chk({oscGain, crystalPadSelect, outPadFree}, 5'h11);
    want <= 4'hF;
    for (int s = 0; s < 4; s += 3) begin
      wb(1, 4'h0, {16'h0, s[3:0], 12'h402});
      waitRun(1);
      ticks(3, (1 << s) - 1);
      cyc(4);
      chk({crystalReadyFlag, clkGrant}, 5'h00);
      ticks(0, 1);
      cyc(4);
      chk({crystalReadyFlag, clkGrant}, 5'h1F);
      wb(1, 4'h0, {16'h0, s[3:0], 12'hC02});
      cyc(2);
      chk(autoAmpGainCtl, 1'b1);
      wb(1, 4'h0, 32'h00000400);
      cyc(3);
      chk({oscRun, autoAmpGainCtl, crystalReadyFlag}, 3'h0);
    end
    want <= 4'h0;
    wb(1, 4'h0, 32'h00000482);
    cyc(3);
    chk(oscRun, 1'b0);
    want <= 4'h2;
    waitRun(1);
    want <= 4'h0;
    waitRun(0);
    standby <= 1;
    wb(1, 4'h0, 32'h00000402);
    waitRun(0);
    want <= 4'h1;
    waitRun(1);
    want <= 4'h0;
    waitRun(0);
    wb(1, 4'h0, 32'h00000442);
    waitRun(1);
    wb(1, 4'h0, 32'h000004C2);
    waitRun(0);
    want <= 4'h8;
    waitRun(1);
    want <= 4'h0;
    standby <= 0;
    // interrupt: raise on ready, clear by writing one, then masked loss
    wb(1, 4'h8, 32'h00000003);
    wb(1, 4'hC, 32'h00000001);
    wb(1, 4'h0, 32'h00000402);
    waitRun(1);
    // frozen clock enable: ticks must be ignored, no ready may appear
    clkEn <= 0;
    ticks(3, 1);
    clkEn <= 1;
    cyc(3);
    chk(crystalReadyFlag, 1'b0);
    ticks(3, 1);
    cyc(4);
    chk(irq, 1'b1);
    wb(0, 4'h8, 0);
    chk(rd, 32'h00000001);
    wb(1, 4'h8, 32'h00000001);
    cyc(2);
    chk(irq, 1'b0);
    wb(1, 4'h0, 32'h00000400);
    cyc(3);
    wb(0, 4'h8, 0);
    chk(rd, 32'h00000002);
    chk(irq, 1'b0);
    end_of_test;
  end
endmodule // crystal_osc_control_tb_top
